// [pkg/dsd_pkg.sv]
/*
  Shared constants and types of the data-space address decoder: the data
  space map, access operation codes, pointer modes, region and state codes.
  Assumes a single core clock domain and byte-wide data accesses.
*/
package dsd_pkg;

  // data space map (byte addresses)
  localparam logic [15:0] IO_LAST     = 16'h003F;
  localparam logic [15:0] SRAM_BASE   = 16'h0040;
  localparam logic [15:0] SRAM_LAST   = 16'h005F;
  localparam logic [15:0] LOCK_BASE   = 16'h3F00;
  localparam logic [15:0] LOCK_LAST   = 16'h3F01;
  localparam logic [15:0] CFG_BASE    = 16'h3F40;
  localparam logic [15:0] CFG_LAST    = 16'h3F41;
  localparam logic [15:0] CAL_BASE    = 16'h3F80;
  localparam logic [15:0] CAL_LAST    = 16'h3F81;
  localparam logic [15:0] ID_BASE     = 16'h3FC0;
  localparam logic [15:0] ID_LAST     = 16'h3FC3;
  localparam logic [15:0] FLASH_BASE  = 16'h4000;
  localparam logic [15:0] DIRECT_BASE = 16'h0040;

  // io bit access limit and sram size
  localparam logic [5:0]  IO_BITOP_LAST = 6'h1F;
  localparam int          SRAM_BYTES    = 32;

  // program memory
  localparam int          FLASH_WORDS_DEF = 512;
  localparam int          PC_W            = 9;
  localparam logic [8:0]  PC_RESET        = 9'h000;

  // pointer pairs start at register 26
  localparam int          PTR_PAIRS = 3;

  typedef enum logic [3:0] {
    OP_DIRECT_LOAD  = 4'h0,
    OP_DIRECT_SAVE  = 4'h1,
    OP_POINTER_LOAD = 4'h2,
    OP_POINTER_SAVE = 4'h3,
    OP_IO_READ      = 4'h4,
    OP_IO_WRITE     = 4'h5,
    OP_IO_BIT_SET   = 4'h6,
    OP_IO_BIT_CLEAR = 4'h7,
    OP_SKIP_IF_SET  = 4'h8,
    OP_SKIP_IF_CLR  = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    PM_PLAIN   = 2'h0,
    PM_PREDEC  = 2'h1,
    PM_POSTINC = 2'h2
  } ptr_mode_t;

  typedef enum logic [7:0] {
    RG_NONE  = 8'h01,
    RG_IO    = 8'h02,
    RG_SRAM  = 8'h04,
    RG_LOCK  = 8'h08,
    RG_CFG   = 8'h10,
    RG_CAL   = 8'h20,
    RG_ID    = 8'h40,
    RG_FLASH = 8'h80
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

endpackage : dsd_pkg

// [pkg/dec_if.sv]
/*
  Carrier between the access sequencer and the region decoder: the
  effective address going in, the selected region and offset coming back.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface dec_if;
  import dsd_pkg::*;
  logic [15:0] addr;
  region_t     region;
  logic [9:0]  offset;

  modport decoder (input addr, output region, output offset);
  modport user    (output addr, input region, input offset);
endinterface : dec_if
`default_nettype wire

// [verilog/region_decode.sv]
/*
  Combinational region decoder for the data space.
  Assumes the address is stable for the whole access cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module region_decode
  import dsd_pkg::*;
#(
  parameter int FLASH_WORDS = FLASH_WORDS_DEF
) (
  dec_if.decoder dec
);
  localparam logic [16:0] FLASH_END = 17'(FLASH_BASE) + 17'(2 * FLASH_WORDS);

  wire         in_io    = dec.addr <= IO_LAST;
  wire         in_sram  = dec.addr >= SRAM_BASE && dec.addr <= SRAM_LAST;
  wire         in_lock  = dec.addr >= LOCK_BASE && dec.addr <= LOCK_LAST;
  wire         in_cfg   = dec.addr >= CFG_BASE && dec.addr <= CFG_LAST;
  wire         in_cal   = dec.addr >= CAL_BASE && dec.addr <= CAL_LAST;
  wire         in_id    = dec.addr >= ID_BASE && dec.addr <= ID_LAST;
  wire         in_flash = dec.addr >= FLASH_BASE &&
                          {1'b0, dec.addr} < FLASH_END;
  wire [15:0]  flash_off = dec.addr - FLASH_BASE;

  assign dec.region = in_io    ? RG_IO :    // [RULE_06]
                      in_sram  ? RG_SRAM :  // [RULE_07]
                      in_lock  ? RG_LOCK :  // [RULE_08]
                      in_cfg   ? RG_CFG :
                      in_cal   ? RG_CAL :
                      in_id    ? RG_ID :
                      in_flash ? RG_FLASH : // [RULE_03]
                      RG_NONE;              // [RULE_21]

  // all small regions are aligned, so their low bits are the offset
  assign dec.offset = in_flash ? flash_off[9:0] : {4'h0, dec.addr[5:0]};
endmodule : region_decode
`default_nettype wire

// [verilog/pointer_unit.sv]
/*
  Pointer register bytes 26..31 viewed as three 16-bit address pairs.
  Assumes the core writes single bytes and the sequencer whole pairs.
*/
`timescale 1ns/1ps
`default_nettype none
module pointer_unit
  import dsd_pkg::*;
(
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  // byte writes from the register file path
  input  wire logic                      byte_we_i,
  input  wire logic [2:0]                byte_idx_i,
  input  wire logic [7:0]                byte_data_i,
  // pair update from the address sequencer
  input  wire logic                      upd_en_i,
  input  wire logic [1:0]                upd_sel_i,
  input  wire logic [15:0]               upd_val_i,
  // pair contents
  output logic [PTR_PAIRS-1:0][15:0]     pair_o
);
  for (genvar p = 0; p < PTR_PAIRS; p++) begin : g_pair
    wire hit_lo = byte_we_i && byte_idx_i == 3'(2 * p);
    wire hit_hi = byte_we_i && byte_idx_i == 3'(2 * p + 1);
    wire upd    = upd_en_i && upd_sel_i == 2'(p);
    // sequencer update wins over a byte write in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pair_o[p] <= 16'h0000;
      end else if (upd) begin
        pair_o[p] <= upd_val_i; // [RULE_11]
      end else if (hit_lo) begin
        pair_o[p][7:0] <= byte_data_i; // [RULE_10]
      end else if (hit_hi) begin
        pair_o[p][15:8] <= byte_data_i; // [RULE_10]
      end
    end
  end
endmodule : pointer_unit
`default_nettype wire

// [verilog/data_space_address_decoder.sv]
/*
  Data-space address decoder: routes core loads, stores and io operations
  to io space, internal sram, read-only nonvolatile bits and mapped flash,
  and holds the program counter, pointer pairs and flash storage.
  Assumes the core holds a request until it is taken, that io peripherals
  honour the write mask, and that all inputs share the core clock.
*/
// Summary of operation
// [RULE_01] flash holds 256 or 512 16-bit words
// [RULE_02] 9-bit program counter starting at zero
// [RULE_03] flash readable in data space from 0x4000
// [RULE_04] core writes to mapped flash do nothing
// [RULE_05] external programming port still writes flash
// [RULE_06] addresses 0x00..0x3F reach io space
// [RULE_07] addresses 0x40..0x5F reach internal sram
// [RULE_08] lock, config, calibration bits at 0x3F00/40/80
// [RULE_09] nonvolatile regions are read only
// [RULE_10] bytes 26..31 form three pointer pairs
// [RULE_11] pre-decrement before, post-increment after access
// [RULE_12] pointer accesses reach the whole data space
// [RULE_13] direct ops reach only 0x40..0xBF
// [RULE_14] io ops use 6-bit addresses 0x00..0x3F
// [RULE_15] io locations reachable by pointer loads, stores
// [RULE_16] bit ops and skips only at io 0x00..0x1F
// [RULE_17] bit set, clear touch only addressed bit
// [RULE_18] some io flags clear by writing one
// [RULE_19] software writes reserved bits zero, avoids holes
// [RULE_20] every access completes in two clocks
// [RULE_21] reserved addresses read zero, ignore writes
// [RULE_22] flash byte reads: even low, odd high
`timescale 1ns/1ps
`default_nettype none
module data_space_address_decoder
  import dsd_pkg::*;
#(
  parameter int FLASH_WORDS = FLASH_WORDS_DEF
) (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // core access request
  input  wire logic                   req_valid_i,
  input  wire op_t                    req_op_i,
  input  wire logic [1:0]             req_ptr_i,
  input  wire ptr_mode_t              req_mode_i,
  input  wire logic [15:0]            req_addr_i,
  input  wire logic [2:0]             req_bit_i,
  input  wire logic [7:0]             req_wdata_i,
  output logic                        req_ready_o,
  output logic                        done_o,
  output logic [7:0]                  rdata_o,
  output logic                        skip_o,
  // pointer register bytes
  input  wire logic                   ptr_byte_we_i,
  input  wire logic [2:0]             ptr_byte_idx_i,
  input  wire logic [7:0]             ptr_byte_data_i,
  output logic [PTR_PAIRS-1:0][15:0]  pointer_pair_o,
  // io register bus
  output logic                        io_rd_o,
  output logic                        io_wr_o,
  output logic [5:0]                  io_addr_o,
  output logic [7:0]                  io_wdata_o,
  output logic [7:0]                  io_wmask_o,
  input  wire logic [7:0]             io_rdata_i,
  // nonvolatile bits
  input  wire logic [15:0]            lock_bits_i,
  input  wire logic [15:0]            config_bits_i,
  input  wire logic [15:0]            calib_bits_i,
  input  wire logic [31:0]            device_id_i,
  // program fetch
  input  wire logic                   pc_step_i,
  input  wire logic                   pc_load_i,
  input  wire logic [PC_W-1:0]        pc_target_i,
  output logic [PC_W-1:0]             program_counter_o,
  output logic [15:0]                 fetch_word_o,
  // external flash programming
  input  wire logic                   prog_we_i,
  input  wire logic [PC_W-1:0]        prog_addr_i,
  input  wire logic [15:0]            prog_data_i
);
  localparam int FW_AW = $clog2(FLASH_WORDS);

  if (FLASH_WORDS != 256 && FLASH_WORDS != 512) begin : g_bad_size
    $error("FLASH_WORDS must be 256 or 512");
  end

  state_t                  state_r;
  state_t                  state_nxt;
  op_t                     op_r;
  logic [15:0]             addr_r;
  logic [2:0]              bit_r;
  logic [7:0]              wdata_r;
  logic [7:0]              wmask_r;
  logic [7:0]              rdata_r;
  logic                    done_r;
  logic                    skip_r;
  logic [PC_W-1:0]         pc_r;
  logic [15:0]             fetch_r;
  logic [7:0]              sram_mem [SRAM_BYTES];
  logic [15:0]             flash_mem [FLASH_WORDS]; // [RULE_01]
  logic [7:0]              rd_mux;

  dec_if dec ();

  region_decode #(
    .FLASH_WORDS (FLASH_WORDS)
  ) u_region (
    .dec (dec)
  );

  // request classification
  wire         accept     = req_valid_i && state_r == ST_IDLE;
  wire         req_is_ptr = req_op_i == OP_POINTER_LOAD ||
                            req_op_i == OP_POINTER_SAVE;
  wire         req_is_dir = req_op_i == OP_DIRECT_LOAD ||
                            req_op_i == OP_DIRECT_SAVE;
  wire         req_set    = req_op_i == OP_IO_BIT_SET;
  wire         req_bitop  = req_set || req_op_i == OP_IO_BIT_CLEAR;
  wire [7:0]   bit_mask   = 8'h01 << req_bit_i;

  // effective address
  wire [15:0]  ptr_cur = pointer_pair_o[req_ptr_i];
  wire [15:0]  ptr_dec = ptr_cur - 16'h0001;
  wire [15:0]  ptr_inc = ptr_cur + 16'h0001;
  wire [15:0]  ptr_eff = req_mode_i == PM_PREDEC ? ptr_dec : ptr_cur;
  wire [15:0]  dir_eff = DIRECT_BASE + {9'h000, req_addr_i[6:0]}; // [RULE_13]
  wire [15:0]  io_eff  = {10'h000, req_addr_i[5:0]};              // [RULE_14]
  wire [15:0]  eff_addr = req_is_ptr ? ptr_eff :                  // [RULE_12]
                          req_is_dir ? dir_eff : io_eff;

  // pointer pair update is applied when the request is taken
  wire         ptr_upd     = accept && req_is_ptr && req_mode_i != PM_PLAIN;
  wire [15:0]  ptr_upd_val = req_mode_i == PM_PREDEC ? ptr_dec : ptr_inc;

  pointer_unit u_ptr (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .byte_we_i   (ptr_byte_we_i),
    .byte_idx_i  (ptr_byte_idx_i),
    .byte_data_i (ptr_byte_data_i),
    .upd_en_i    (ptr_upd),       // [RULE_11]
    .upd_sel_i   (req_ptr_i),
    .upd_val_i   (ptr_upd_val),
    .pair_o      (pointer_pair_o)
  );

  // access phase decode
  assign dec.addr = addr_r;
  wire         exec      = state_r == ST_EXEC;
  wire         is_write  = op_r == OP_DIRECT_SAVE || op_r == OP_POINTER_SAVE ||
                           op_r == OP_IO_WRITE;
  wire         is_bitop  = op_r == OP_IO_BIT_SET || op_r == OP_IO_BIT_CLEAR;
  wire         is_skip   = op_r == OP_SKIP_IF_SET || op_r == OP_SKIP_IF_CLR;
  wire         bit_ok    = addr_r[5:0] <= IO_BITOP_LAST;          // [RULE_16]
  wire         hit_io    = dec.region == RG_IO;                   // [RULE_15]
  wire         hit_sram  = dec.region == RG_SRAM;
  wire         sram_we   = exec && hit_sram && is_write;
  wire [4:0]   sram_idx  = dec.offset[4:0];
  wire [FW_AW-1:0] fl_idx = dec.offset[FW_AW:1];
  wire [15:0]  fl_word   = flash_mem[fl_idx];
  wire [7:0]   fl_byte   = dec.offset[0] ? fl_word[15:8] : fl_word[7:0]; // [RULE_22]
  wire         io_bit    = io_rdata_i[bit_r];

  // io strobes; bit ops and skips above the bit-access range are dropped
  assign io_rd_o = exec && hit_io && !is_write && !is_bitop &&
                   (!is_skip || bit_ok);                         // [RULE_16]
  assign io_wr_o = exec && hit_io && (is_write || (is_bitop && bit_ok));
  // a masked write lets write-one-to-clear flags nearby survive
  assign io_addr_o  = addr_r[5:0];
  assign io_wdata_o = wdata_r;                                    // [RULE_18]
  assign io_wmask_o = wmask_r;                                    // [RULE_17]

  // read data selection
  always_comb begin
    case (dec.region)
      RG_IO:    rd_mux = io_rdata_i;
      RG_SRAM:  rd_mux = sram_mem[sram_idx];
      RG_LOCK:  rd_mux = dec.offset[0] ? lock_bits_i[15:8] : lock_bits_i[7:0];
      RG_CFG:   rd_mux = dec.offset[0] ? config_bits_i[15:8]
                                       : config_bits_i[7:0];
      RG_CAL:   rd_mux = dec.offset[0] ? calib_bits_i[15:8]
                                       : calib_bits_i[7:0];
      RG_ID:    rd_mux = device_id_i[8*dec.offset[1:0] +: 8];
      RG_FLASH: rd_mux = fl_byte;                                 // [RULE_03]
      default:  rd_mux = 8'h00;                                   // [RULE_21]
    endcase
  end

  // sequencer
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = accept ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = ST_IDLE;                               // [RULE_20]
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign req_ready_o = state_r == ST_IDLE;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_r    <= OP_DIRECT_LOAD;
      addr_r  <= 16'h0000;
      bit_r   <= 3'h0;
      wdata_r <= 8'h00;
      wmask_r <= 8'h00;
    end else if (accept) begin
      op_r    <= req_op_i;
      addr_r  <= eff_addr;
      bit_r   <= req_bit_i;
      wdata_r <= req_bitop ? (req_set ? bit_mask : 8'h00) : req_wdata_i;
      wmask_r <= req_bitop ? bit_mask : 8'hFF;                    // [RULE_17]
    end
  end

  // answer: done two clocks after the request edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
      skip_r  <= 1'b0;
    end else begin
      done_r <= exec;                                             // [RULE_20]
      skip_r <= exec && is_skip && bit_ok && hit_io &&
                (io_bit == (op_r == OP_SKIP_IF_SET));             // [RULE_16]
      if (exec && !is_write && !is_bitop) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign done_o  = done_r;
  assign rdata_o = rdata_r;
  assign skip_o  = skip_r;

  // only sram and io space (via the io bus) take core writes; every other region ignores them
  always_ff @(posedge ref_clk_i) begin
    if (sram_we) begin
      sram_mem[sram_idx] <= wdata_r;                              // [RULE_09]
    end
  end

  // flash is written by the programming port alone
  always_ff @(posedge ref_clk_i) begin
    if (prog_we_i) begin
      flash_mem[prog_addr_i[FW_AW-1:0]] <= prog_data_i;          // [RULE_05]
    end
  end                                                            // [RULE_04]

  // program counter and fetch
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_r    <= PC_RESET;                                        // [RULE_02]
      fetch_r <= 16'h0000;
    end else begin
      if (pc_load_i) begin
        pc_r <= pc_target_i;
      end else if (pc_step_i) begin
        pc_r <= pc_r + 9'h001;
      end
      fetch_r <= flash_mem[pc_r[FW_AW-1:0]];
    end
  end

  assign program_counter_o = pc_r;
  assign fetch_word_o      = fetch_r;

endmodule : data_space_address_decoder
`default_nettype wire

// [verif/dsd_checker.sv]
/* assertions on access timing, io bus and counters.
   assumes a bind into the decoder. */
`timescale 1ns/1ps
`default_nettype none
module dsd_checker
  import dsd_pkg::*;
(
  // clock and reset
  input wire logic                     ref_clk_i,
  input wire logic                     rst_n_i,
  // core request
  input wire logic                     req_valid_i,
  input wire op_t                      req_op_i,
  input wire logic [1:0]               req_ptr_i,
  input wire ptr_mode_t                req_mode_i,
  input wire logic [15:0]              req_addr_i,
  input wire logic [2:0]               req_bit_i,
  input wire logic [7:0]               req_wdata_i,
  input wire logic                     req_ready_o,
  input wire logic                     done_o,
  input wire logic                     skip_o,
  input wire logic [PTR_PAIRS-1:0][15:0] pointer_pair_o,
  // io bus and program counter
  input wire logic                     io_rd_o,
  input wire logic                     io_wr_o,
  input wire logic [5:0]               io_addr_o,
  input wire logic [7:0]               io_wdata_o,
  input wire logic [7:0]               io_wmask_o,
  input wire logic                     pc_step_i,
  input wire logic                     pc_load_i,
  input wire logic [PC_W-1:0]          pc_target_i,
  input wire logic [PC_W-1:0]          program_counter_o
);
  wire taken = req_valid_i && req_ready_o;
  wire bit_op = req_op_i == OP_IO_BIT_SET || req_op_i == OP_IO_BIT_CLEAR;
  wire skp_op = req_op_i == OP_SKIP_IF_SET || req_op_i == OP_SKIP_IF_CLR;
  wire ptr_op = req_op_i == OP_POINTER_LOAD || req_op_i == OP_POINTER_SAVE;
  wire lo_io = req_addr_i[5:0] <= IO_BITOP_LAST;
  wire [15:0] sel_pair = pointer_pair_o[req_ptr_i];
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  done_two_cycles_a: assert property (taken |=> !req_ready_o ##1 done_o)
    else $error("done not two cycles after request");
  done_has_cause_a: assert property (done_o |-> $past(taken, 2))
    else $error("done without request");
  io_write_fwd_a: assert property (taken && req_op_i == OP_IO_WRITE |=>
    io_wr_o && io_addr_o == $past(req_addr_i[5:0])
    && io_wdata_o == $past(req_wdata_i)) else $error("io write wrong");
  io_read_once_a: assert property (taken && req_op_i == OP_IO_READ |=>
    io_rd_o && io_addr_o == $past(req_addr_i[5:0]) ##1 !io_rd_o)
    else $error("io read strobe wrong");
  bit_mask_a: assert property (taken && bit_op && lo_io |=>
    io_wr_o && io_wmask_o == (8'h01 << $past(req_bit_i)))
    else $error("bit op mask wrong");
  bit_limit_a: assert property (taken && bit_op && !lo_io |=>
    !io_wr_o && !io_rd_o) else $error("bit op above limit");
  skip_limit_a: assert property (taken && skp_op && !lo_io |->
    ##2 done_o && !skip_o) else $error("skip above limit");
  direct_no_io_a: assert property (taken && req_op_i == OP_DIRECT_SAVE
    |=> !io_wr_o) else $error("direct save reached io");
  post_inc_a: assert property (taken && ptr_op && req_mode_i == PM_POSTINC
    |=> pointer_pair_o[$past(req_ptr_i)] == $past(sel_pair) + 16'h0001)
    else $error("post increment wrong");
  pre_dec_a: assert property (taken && ptr_op && req_mode_i == PM_PREDEC
    |=> pointer_pair_o[$past(req_ptr_i)] == $past(sel_pair) - 16'h0001)
    else $error("pre decrement wrong");
  pc_step_a: assert property (pc_step_i && !pc_load_i |=>
    program_counter_o == 9'($past(program_counter_o) + 9'h001))
    else $error("pc step wrong");
  pc_load_a: assert property (pc_load_i |=>
    program_counter_o == $past(pc_target_i)) else $error("pc load wrong");
  cov_skip_c: cover property (taken && skp_op ##2 skip_o);
  cov_bit_c: cover property (taken && bit_op ##1 io_wr_o);
  cov_post_c: cover property (taken && ptr_op && req_mode_i == PM_POSTINC);
endmodule : dsd_checker
bind data_space_address_decoder dsd_checker u_chk (.*);
`default_nettype wire

// [verif/io_periph_model.sv]
/* io peripheral model: 64 byte registers, one write-one-to-clear flag byte.
   assumes strobes and address from the decoder's io bus. */
`timescale 1ns/1ps
`default_nettype none
module io_periph_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [5:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] wmask_i,
  output logic [7:0]      rdata_o
);
  localparam logic [5:0] FLAG_ADDR = 6'h05;
  logic [7:0] regs_r [64];
  logic [7:0] last_r;
  wire [7:0] sel = regs_r[addr_i];
  // released bus shows the inverse of the last value
  assign rdata_o = rd_i ? sel : ~last_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 64; i++) regs_r[i] <= (i == 5) ? 8'hFF : 8'h00;
      last_r <= 8'h00;
    end else begin
      if (rd_i) last_r <= sel;
      if (wr_i && addr_i == FLAG_ADDR) regs_r[addr_i] <= sel & ~(wdata_i & wmask_i);
      else if (wr_i) regs_r[addr_i] <= (sel & ~wmask_i) | (wdata_i & wmask_i);
    end
  end
endmodule : io_periph_model
`default_nettype wire

// [verif/test_data_space_address_decoder.sv]
/* self-checking bench of the decoder with an io model.
   assumes the checker is bound in. */
`timescale 1ns/1ps
`default_nettype none
module test_data_space_address_decoder;
  import dsd_pkg::*;
  typedef struct packed { logic [1:0] ck; logic [7:0] val; } note_t;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0;
  op_t req_op_i = OP_DIRECT_LOAD;
  ptr_mode_t req_mode_i = PM_PLAIN;
  logic [1:0] req_ptr_i = 2'h0;
  logic [15:0] req_addr_i = 16'h0000;
  logic [2:0] req_bit_i = 3'h0, ptr_byte_idx_i = 3'h0;
  logic [7:0] req_wdata_i = 8'h00, ptr_byte_data_i = 8'h00, rdata_o, io_rdata_i;
  logic req_ready_o, done_o, skip_o, io_rd_o, io_wr_o, ptr_byte_we_i = 1'b0;
  logic [PTR_PAIRS-1:0][15:0] pointer_pair_o;
  logic [5:0] io_addr_o;
  logic [7:0] io_wdata_o, io_wmask_o, d, e;
  logic [15:0] lock_bits_i = 16'h0000, config_bits_i = 16'h0000;
  logic [15:0] calib_bits_i = 16'h0000, fetch_word_o, prog_data_i = 16'h0000;
  logic [31:0] device_id_i = 32'h0000_0000, seed = 32'h286b;
  logic pc_step_i = 1'b0, pc_load_i = 1'b0, prog_we_i = 1'b0;
  logic [PC_W-1:0] pc_target_i = 9'h000, prog_addr_i = 9'h000, program_counter_o;
  logic [15:0] fw [4], nv [4];
  logic [7:0] sd [8];
  note_t notes[$], nt;
  int n_errors = 0, compares = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  data_space_address_decoder dut (.*);
  io_periph_model u_io (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .rd_i(io_rd_o), .wr_i(io_wr_o), .addr_i(io_addr_o), .wdata_i(io_wdata_o),
    .wmask_i(io_wmask_o), .rdata_o(io_rdata_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [15:0] s, exp);
    compares++;
    if (s !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, s);
    end
  endtask : check
  // ck[1]: compare read data, ck[0]: compare skip flag against x[0]
  task automatic acc(input op_t op, input logic [15:0] a, input logic [7:0] w,
      input logic [2:0] b, input logic [1:0] p, input ptr_mode_t m,
      input logic [1:0] ck, input logic [7:0] x);
    int n = 0;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_op_i <= op;
    req_addr_i <= a;
    req_wdata_i <= w;
    req_bit_i <= b;
    req_ptr_i <= p;
    req_mode_i <= m;
    notes.push_back({ck, x});
    @(negedge ref_clk_i);
    while (req_ready_o !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        end_of_test();
      end
      @(negedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
  endtask : acc
  task automatic set_ptr(input logic [1:0] p, input logic [15:0] v);
    @(posedge ref_clk_i);
    ptr_byte_we_i <= 1'b1;
    ptr_byte_idx_i <= {p, 1'b0};
    ptr_byte_data_i <= v[7:0];
    @(posedge ref_clk_i);
    ptr_byte_idx_i <= {p, 1'b1};
    ptr_byte_data_i <= v[15:8];
    @(posedge ref_clk_i);
    ptr_byte_we_i <= 1'b0;
  endtask : set_ptr
  always @(negedge ref_clk_i) begin
    if (done_o === 1'b1) begin
      if (notes.size() == 0) check("done", 16'h0001, 16'h0000);
      else begin
        nt = notes.pop_front();
        if (nt.ck[1]) check("rdata", rdata_o, nt.val);
        if (nt.ck[0]) check("skip", skip_o, nt.val[0]);
      end
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      fw[i] = seed[15:0];
      nv[i] = seed[31:16];
      @(posedge ref_clk_i);
      prog_we_i <= 1'b1;
      prog_addr_i <= 9'(i);
      prog_data_i <= fw[i];
    end
    lock_bits_i <= nv[0];
    config_bits_i <= nv[1];
    calib_bits_i <= nv[2];
    device_id_i <= {~nv[3], nv[3]};
    @(posedge ref_clk_i);
    prog_we_i <= 1'b0;
    pc_load_i <= 1'b1;
    pc_target_i <= 9'h002;
    @(posedge ref_clk_i);
    pc_load_i <= 1'b0;
    pc_step_i <= 1'b1;
    @(posedge ref_clk_i);
    pc_step_i <= 1'b0;
    @(negedge ref_clk_i);
    check("pc", program_counter_o, 16'h0003);
    check("fetch", fetch_word_o, fw[2]);
    set_ptr(2'd0, FLASH_BASE);
    for (int i = 0; i < 4; i++)
      acc(OP_POINTER_LOAD, 0, 0, 0, 0, PM_POSTINC, 2'b10,
          i[0] ? fw[i/2][15:8] : fw[i/2][7:0]);
    acc(OP_POINTER_SAVE, 0, ~fw[1][15:8], 0, 0, PM_PREDEC, 2'b00, 0);
    acc(OP_POINTER_LOAD, 0, 0, 0, 0, PM_PLAIN, 2'b10, fw[1][15:8]);
    set_ptr(2'd1, 16'h4400);
    acc(OP_POINTER_LOAD, 0, 0, 0, 1, PM_PLAIN, 2'b10, 8'h00);
    for (int k = 0; k < 4; k++) begin
      set_ptr(2'd2, LOCK_BASE + 16'(k * 64));
      acc(OP_POINTER_LOAD, 0, 0, 0, 2, PM_POSTINC, 2'b10, nv[k][7:0]);
      acc(OP_POINTER_SAVE, 0, 8'hA5, 0, 2, PM_PREDEC, 2'b00, 0);
      acc(OP_POINTER_LOAD, 0, 0, 0, 2, PM_POSTINC, 2'b10, nv[k][7:0]);
      acc(OP_POINTER_LOAD, 0, 0, 0, 2, PM_PLAIN, 2'b10, nv[k][15:8]);
    end
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      sd[i] = seed[7:0];
      acc(OP_DIRECT_SAVE, 16'(i * 4 + 3), sd[i], 0, 0, PM_PLAIN, 2'b00, 0);
    end
    acc(OP_DIRECT_SAVE, 16'h007F, ~sd[7], 0, 0, PM_PLAIN, 2'b00, 0);
    for (int i = 0; i < 8; i++)
      acc(OP_DIRECT_LOAD, 16'(i * 4 + 3), 0, 0, 0, PM_PLAIN, 2'b10, sd[i]);
    acc(OP_DIRECT_LOAD, 16'h007F, 0, 0, 0, PM_PLAIN, 2'b10, 8'h00);
    d = seed[15:8];
    e = seed[23:16];
    acc(OP_IO_WRITE, 16'h0010, d, 0, 0, PM_PLAIN, 2'b00, 0);
    acc(OP_IO_READ, 16'h0010, 0, 0, 0, PM_PLAIN, 2'b10, d);
    set_ptr(2'd1, 16'h0010);
    acc(OP_POINTER_LOAD, 0, 0, 0, 1, PM_PLAIN, 2'b10, d);
    acc(OP_POINTER_SAVE, 0, e, 0, 1, PM_PLAIN, 2'b00, 0);
    acc(OP_IO_READ, 16'h0010, 0, 0, 0, PM_PLAIN, 2'b10, e);
    acc(OP_IO_BIT_SET, 16'h0010, 0, 3'd2, 0, PM_PLAIN, 2'b00, 0);
    acc(OP_IO_READ, 16'h0010, 0, 0, 0, PM_PLAIN, 2'b10, e | 8'h04);
    acc(OP_IO_BIT_CLEAR, 16'h0010, 0, 3'd2, 0, PM_PLAIN, 2'b00, 0);
    acc(OP_SKIP_IF_CLR, 16'h0010, 0, 3'd2, 0, PM_PLAIN, 2'b01, 1);
    acc(OP_SKIP_IF_SET, 16'h0010, 0, 3'd2, 0, PM_PLAIN, 2'b01, 0);
    acc(OP_IO_BIT_SET, 16'h0025, 0, 3'd0, 0, PM_PLAIN, 2'b00, 0);
    acc(OP_IO_READ, 16'h0025, 0, 0, 0, PM_PLAIN, 2'b10, 8'h00);
    acc(OP_SKIP_IF_CLR, 16'h0025, 0, 3'd0, 0, PM_PLAIN, 2'b01, 0);
    acc(OP_IO_BIT_SET, 16'h0005, 0, 3'd3, 0, PM_PLAIN, 2'b00, 0);
    acc(OP_IO_BIT_CLEAR, 16'h0005, 0, 3'd4, 0, PM_PLAIN, 2'b00, 0);
    acc(OP_IO_READ, 16'h0005, 0, 0, 0, PM_PLAIN, 2'b10, 8'hF7);
    for (int n = 0; n < 50 && notes.size() != 0; n++) @(negedge ref_clk_i);
    check("pending", 16'(notes.size()), 16'h0000);
    end_of_test();
  end
endmodule : test_data_space_address_decoder
`default_nettype wire
